/* core/quad_pos_pkg.sv */
// Shared constants for the encoder position input block.
package quad_pos_pkg;

    // ------------------------------------------------------------
    // Bus and data widths
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned IRQ_W = 3;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] PRESCALE_OFS = 8'h04;
    localparam logic [7:0] POSTSCALE_OFS = 8'h08;
    localparam logic [7:0] TGT_MAX_OFS = 8'h0C;
    localparam logic [7:0] TGT_MIN_OFS = 8'h10;
    localparam logic [7:0] RAW_COUNT_OFS = 8'h14;
    localparam logic [7:0] SCALED_OFS = 8'h18;
    localparam logic [7:0] POSITION_OFS = 8'h1C;
    localparam logic [7:0] SKIP_COUNT_OFS = 8'h20;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h24;
    localparam logic [7:0] IRQ_ENABLE_OFS = 8'h28;
    localparam logic [7:0] IRQ_CLEAR_OFS = 8'h2C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned ENC_MODE_BIT = 0;
    localparam int unsigned UNBOUNDED_BIT = 1;
    localparam int unsigned INVERT_DIR_BIT = 2;
    localparam int unsigned IRQ_SKIP_BIT = 0;
    localparam int unsigned IRQ_CLAMP_BIT = 1;
    localparam int unsigned IRQ_ARRIVED_BIT = 2;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic signed [31:0] PRESCALE_RST = 32'h0000_0001;
    localparam logic signed [31:0] POSTSCALE_RST = 32'h0000_0001;
    localparam logic signed [31:0] TGT_MAX_RST = 32'h0000_00C8;
    localparam logic signed [31:0] TGT_MIN_RST = 32'hFFFF_FF38;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned STEP_PERIOD_NS = 10000;
    localparam int unsigned STEP_DIV_CYC = (STEP_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* core/quad_evt_if.sv */
// Count events passed from the channel decoder to the position logic.
`timescale 1ns/1ps
`default_nettype none
interface quad_evt_if;
    logic up;
    logic down;
    logic skip;
    modport src (output up, output down, output skip);
    modport dst (input up, input down, input skip);
endinterface
`default_nettype wire

/* core/quad_decoder.sv */
// Two-channel quadrature decoder with input synchronisers.
`timescale 1ns/1ps
`default_nettype none
module quad_decoder
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Control
    input wire logic enable,
    // Channel pins
    input wire logic ch_a,
    input wire logic ch_b,
    // Events
    quad_evt_if.src evt
);

    logic a_s1_r;
    logic a_s2_r;
    logic b_s1_r;
    logic b_s2_r;
    logic a_q_r;
    logic b_q_r;
    logic da;
    logic db;

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    // Idle level is high because the pins float high between detents.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            a_s1_r <= 1'b1;
            a_s2_r <= 1'b1;
            b_s1_r <= 1'b1;
            b_s2_r <= 1'b1;
        end
        else
        begin
            a_s1_r <= ch_a;
            a_s2_r <= a_s1_r;
            b_s1_r <= ch_b;
            b_s2_r <= b_s1_r;
        end
    end

    assign da = a_s2_r ^ a_q_r;
    assign db = b_s2_r ^ b_q_r;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // A change on both channels at once means a state was missed, so its direction is unknown.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            a_q_r <= 1'b1;
            b_q_r <= 1'b1;
            evt.up <= 1'b0;
            evt.down <= 1'b0;
            evt.skip <= 1'b0;
        end
        else
        begin
            a_q_r <= a_s2_r;
            b_q_r <= b_s2_r;
            evt.up <= enable && (da ^ db) && (a_s2_r ^ b_q_r);
            evt.down <= enable && (da ^ db) && !(a_s2_r ^ b_q_r);
            evt.skip <= enable && da && db;
        end
    end

endmodule
`default_nettype wire

/* core/step_pulser.sv */
// Step and direction generator that walks the motor position to the target.
`timescale 1ns/1ps
`default_nettype none
module step_pulser
#(
    parameter int unsigned DIV_CYC = quad_pos_pkg::STEP_DIV_CYC
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Control
    input wire logic run,
    input wire logic invert,
    input wire logic signed [31:0] target,
    // Motor
    output logic step_r,
    output logic dir_r,
    output logic signed [31:0] position_r,
    output logic arrived_r
);

    localparam int unsigned CNT_W = $clog2(DIV_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DIV_CYC - 1);

    logic [CNT_W-1:0] div_r;
    logic tick;
    logic ahead;

    if (DIV_CYC < 2)
    begin : gen_chk
        $error("step_pulser needs DIV_CYC of at least 2");
    end

    // ------------------------------------------------------------
    // Rate divider
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst || div_r == CNT_LAST)
            div_r <= '0;
        else
            div_r <= div_r + CNT_W'(1);
    end

    assign tick = (div_r == CNT_LAST);
    assign ahead = (target > position_r);

    // ------------------------------------------------------------
    // Stepping
    // ------------------------------------------------------------
    // Direction is refreshed every cycle from the same comparison as the step, so it can change on the same edge as a step.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            step_r <= 1'b0;
            dir_r <= 1'b0;
            position_r <= '0;
            arrived_r <= 1'b0;
        end
        else
        begin
            dir_r <= ahead ^ invert;
            step_r <= 1'b0;
            arrived_r <= 1'b0;
            if (run && tick && position_r != target)
            begin
                step_r <= 1'b1;
                position_r <= ahead ? position_r + 32'sd1 : position_r - 32'sd1;
                arrived_r <= ahead ? (position_r + 32'sd1 == target) : (position_r - 32'sd1 == target);
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    step_track_a: assert property (run && tick && position_r != target |=> step_r && position_r == $past(position_r) + ($past(ahead) ? 32'sd1 : -32'sd1)) else $error("step did not move toward target");
    dir_invert_a: assert property (step_r |-> dir_r == ($past(ahead) ^ $past(invert))) else $error("direction pin wrong for target and inversion");

endmodule
`default_nettype wire

/* core/quadrature_position_input.sv */
// Encoder position control path: decoding, scaling, limits, stepping and registers.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module quadrature_position_input
#(
    parameter int unsigned STEP_DIV = quad_pos_pkg::STEP_DIV_CYC
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [quad_pos_pkg::ADDR_W-1:0] addr,
    input wire logic [quad_pos_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [quad_pos_pkg::DATA_W-1:0] rdata,
    // Encoder and serial pins
    input wire logic rx_pin,
    input wire logic tx_pin_in,
    input wire logic ser_txd,
    output logic tx_out,
    output logic tx_oe_n,
    output logic pullup_en,
    // Motor
    input wire logic motor_power,
    output logic step_out,
    output logic dir_out,
    // Interrupt
    output logic irq
);

    localparam logic signed [31:0] SMAX = 32'h7FFF_FFFF;

    quad_evt_if evt ();

    logic [2:0] ctrl_r;
    logic signed [31:0] presc_r;
    logic signed [31:0] post_r;
    logic signed [31:0] tmax_r;
    logic signed [31:0] tmin_r;
    logic signed [31:0] raw_r;
    logic signed [31:0] acc_r;
    logic signed [31:0] acc_nxt;
    logic signed [31:0] acc_step;
    logic signed [31:0] scaled_r;
    logic signed [31:0] scaled_nxt;
    logic signed [31:0] scaled_raw;
    logic signed [31:0] position;
    logic [31:0] skip_cnt_r;
    logic [quad_pos_pkg::IRQ_W-1:0] irq_stat_r;
    logic [quad_pos_pkg::IRQ_W-1:0] irq_stat_nxt;
    logic [quad_pos_pkg::IRQ_W-1:0] irq_en_r;
    logic [quad_pos_pkg::IRQ_W-1:0] irq_clr;
    logic [quad_pos_pkg::IRQ_W-1:0] events;
    logic pwr_s1_r;
    logic pwr_s_r;
    logic rdata_en_r;
    logic [quad_pos_pkg::DATA_W-1:0] rmux_r;
    logic clamp_evt;
    logic arrived;
    logic step_q;
    logic dir_q;
    logic enc_mode;
    logic unbounded;

    assign enc_mode = ctrl_r[quad_pos_pkg::ENC_MODE_BIT];
    assign unbounded = ctrl_r[quad_pos_pkg::UNBOUNDED_BIT];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic signed [31:0] clamp_to(input logic signed [31:0] v, input logic signed [31:0] hi,
                                                    input logic signed [31:0] lo);
        if (v > hi)
            clamp_to = hi;
        else if (v < lo)
            clamp_to = lo;
        else
            clamp_to = v;
    endfunction

    // ------------------------------------------------------------
    // Motor power synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pwr_s1_r <= 1'b0;
            pwr_s_r <= 1'b0;
        end
        else
        begin
            pwr_s1_r <= motor_power;
            pwr_s_r <= pwr_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Decoder
    // ------------------------------------------------------------
    quad_decoder u_dec
    (
        .clk(clk),
        .srst(srst),
        .enable(enc_mode),
        .ch_a(rx_pin),
        .ch_b(tx_pin_in),
        .evt(evt)
    );

    // ------------------------------------------------------------
    // Pin sharing
    // ------------------------------------------------------------
    // While the encoder owns the lines the TX driver stays off, so an encoder output is never fought.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            tx_out <= 1'b1;
            tx_oe_n <= 1'b1;
            pullup_en <= 1'b0;
        end
        else
        begin
            tx_out <= ser_txd;
            tx_oe_n <= enc_mode;
            pullup_en <= enc_mode;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Limits of the wrong sign and a zero prescaler are corrected on write rather than refused.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_r <= quad_pos_pkg::CTRL_RST;
            presc_r <= quad_pos_pkg::PRESCALE_RST;
            post_r <= quad_pos_pkg::POSTSCALE_RST;
            tmax_r <= quad_pos_pkg::TGT_MAX_RST;
            tmin_r <= quad_pos_pkg::TGT_MIN_RST;
            irq_en_r <= '0;
        end
        else if (wr_en)
        begin
            if (hit(addr, quad_pos_pkg::CTRL_OFS))
                ctrl_r <= wdata[2:0];
            if (hit(addr, quad_pos_pkg::PRESCALE_OFS))
                presc_r <= ($signed(wdata) < 32'sd1) ? 32'sd1 : $signed(wdata);
            if (hit(addr, quad_pos_pkg::POSTSCALE_OFS))
                post_r <= $signed(wdata);
            if (hit(addr, quad_pos_pkg::TGT_MAX_OFS))
                tmax_r <= ($signed(wdata) < 32'sd0) ? 32'sd0 : $signed(wdata);
            if (hit(addr, quad_pos_pkg::TGT_MIN_OFS))
                tmin_r <= ($signed(wdata) > 32'sd0) ? 32'sd0 : $signed(wdata);
            if (hit(addr, quad_pos_pkg::IRQ_ENABLE_OFS))
                irq_en_r <= wdata[quad_pos_pkg::IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Raw count
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst || !pwr_s_r)
            raw_r <= '0;
        else if (evt.up)
            raw_r <= raw_r + 32'sd1;
        else if (evt.down)
            raw_r <= raw_r - 32'sd1;
    end

    // ------------------------------------------------------------
    // Scaling and limits
    // ------------------------------------------------------------
    // One scaling step per cycle is plenty: counts arrive thousands of cycles apart.
    always_comb
    begin
        acc_step = acc_r;
        if (pwr_s_r && evt.up)
            acc_step = acc_r + 32'sd1;
        else if (pwr_s_r && evt.down)
            acc_step = acc_r - 32'sd1;
        acc_nxt = acc_step;
        scaled_raw = scaled_r;
        if (acc_step >= presc_r)
        begin
            acc_nxt = acc_step - presc_r;
            scaled_raw = scaled_r + post_r;
        end
        else if (acc_step <= -presc_r)
        begin
            acc_nxt = acc_step + presc_r;
            scaled_raw = scaled_r - post_r;
        end
        if (!pwr_s_r)
            acc_nxt = '0;
        if (unbounded)
            scaled_nxt = scaled_raw;
        else
            scaled_nxt = clamp_to(scaled_raw, tmax_r, tmin_r);
        clamp_evt = !unbounded && (scaled_raw != scaled_r) && (scaled_nxt != scaled_raw);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            acc_r <= '0;
            scaled_r <= '0;
        end
        else
        begin
            acc_r <= acc_nxt;
            scaled_r <= scaled_nxt;
        end
    end

    // ------------------------------------------------------------
    // Stepper
    // ------------------------------------------------------------
    step_pulser #(.DIV_CYC(STEP_DIV)) u_step
    (
        .clk(clk),
        .srst(srst),
        .run(pwr_s_r),
        .invert(ctrl_r[quad_pos_pkg::INVERT_DIR_BIT]),
        .target(scaled_r),
        .step_r(step_q),
        .dir_r(dir_q),
        .position_r(position),
        .arrived_r(arrived)
    );

    assign step_out = step_q;
    assign dir_out = dir_q;

    // ------------------------------------------------------------
    // Skip count
    // ------------------------------------------------------------
    // Saturates so a long burst of bad input cannot wrap back to a clean reading.
    always_ff @(posedge clk)
    begin
        if (srst)
            skip_cnt_r <= '0;
        else if (evt.skip && skip_cnt_r != 32'hFFFF_FFFF)
            skip_cnt_r <= skip_cnt_r + 32'h0000_0001;
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    always_comb
    begin
        events = '0;
        events[quad_pos_pkg::IRQ_SKIP_BIT] = evt.skip;
        events[quad_pos_pkg::IRQ_CLAMP_BIT] = clamp_evt;
        events[quad_pos_pkg::IRQ_ARRIVED_BIT] = arrived;
        irq_clr = (wr_en && hit(addr, quad_pos_pkg::IRQ_CLEAR_OFS)) ? wdata[quad_pos_pkg::IRQ_W-1:0] : '0;
        irq_stat_nxt = (irq_stat_r & ~irq_clr) | events;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            irq_stat_r <= '0;
            irq <= 1'b0;
        end
        else
        begin
            irq_stat_r <= irq_stat_nxt;
            irq <= |(irq_stat_nxt & irq_en_r);
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst || !rd_en)
            rmux_r <= '0;
        else
        begin
            case (addr)
                quad_pos_pkg::CTRL_OFS: rmux_r <= {29'h0000_0000, ctrl_r};
                quad_pos_pkg::PRESCALE_OFS: rmux_r <= presc_r;
                quad_pos_pkg::POSTSCALE_OFS: rmux_r <= post_r;
                quad_pos_pkg::TGT_MAX_OFS: rmux_r <= tmax_r;
                quad_pos_pkg::TGT_MIN_OFS: rmux_r <= tmin_r;
                quad_pos_pkg::RAW_COUNT_OFS: rmux_r <= raw_r;
                quad_pos_pkg::SCALED_OFS: rmux_r <= scaled_r;
                quad_pos_pkg::POSITION_OFS: rmux_r <= position;
                quad_pos_pkg::SKIP_COUNT_OFS: rmux_r <= skip_cnt_r;
                quad_pos_pkg::IRQ_STATUS_OFS: rmux_r <= {29'h0000_0000, irq_stat_r};
                quad_pos_pkg::IRQ_ENABLE_OFS: rmux_r <= {29'h0000_0000, irq_en_r};
                default: rmux_r <= '0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            rdata_en_r <= 1'b0;
        else
            rdata_en_r <= rd_en;
    end

    assign rdata = rmux_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    pins_released_a: assert property (enc_mode |=> tx_oe_n && pullup_en) else $error("encoder mode left TX driven or pull-up off");
    raw_count_a: assert property (pwr_s_r && evt.up |=> raw_r == $past(raw_r) + 32'sd1) else $error("raw count missed an up step");
    raw_pinned_a: assert property (!pwr_s_r |=> raw_r == 32'sd0) else $error("raw count not zero without power");
    scale_step_a: assert property (unbounded && acc_step >= presc_r |=> scaled_r == $past(scaled_r) + $past(post_r)) else $error("scaled value missed postscale step");
    reset_values_a: assert property ($past(srst) |-> presc_r == 32'sd1 && post_r == 32'sd1 && tmax_r == 32'sd200 && tmin_r == -32'sd200 && !unbounded) else $error("wrong values after reset");
    limit_sign_a: assert property (tmax_r >= 32'sd0 && tmin_r <= 32'sd0) else $error("limit has wrong sign");
    target_bound_a: assert property (!unbounded && $past(!unbounded) && $stable(tmax_r) && $stable(tmin_r) |-> scaled_r <= tmax_r && scaled_r >= tmin_r) else $error("target outside limits");
    remainder_kept_a: assert property (pwr_s_r && $stable(presc_r) && acc_step < presc_r && acc_step > -presc_r |=> acc_r == $past(acc_step)) else $error("raw remainder lost");
    skip_count_a: assert property (evt.skip && skip_cnt_r != 32'hFFFF_FFFF |=> skip_cnt_r == $past(skip_cnt_r) + 32'h0000_0001) else $error("skip not counted");
    irq_raise_a: assert property (evt.skip && irq_en_r[quad_pos_pkg::IRQ_SKIP_BIT] |=> irq && irq_stat_r[quad_pos_pkg::IRQ_SKIP_BIT]) else $error("skip did not raise interrupt");
    read_idle_a: assert property (!rdata_en_r |-> rdata == '0) else $error("read data shown outside its cycle");

endmodule
`default_nettype wire

/* test/enc_knob.sv */
// Behavioural hand-turned quadrature knob that drives the two channel pins.
`timescale 1ns/1ps
`default_nettype none
module enc_knob
#(
    parameter int unsigned GAP_CYC = 10000
)
(
    // Clock
    input wire logic clk,
    // Turn request
    input wire logic go,
    input wire logic back,
    input wire logic jump,
    // Channel pins and busy flag
    output logic ch_a,
    output logic ch_b,
    output logic busy
);
    // Phase 2 is both channels floating, seen high through the pull-ups.
    logic [1:0] ph = 2'h2;
    int unsigned wait_cnt = 0;
    // A jump changes both channels at once, which only the skip test asks for.
    always_ff @(posedge clk)
    begin
        if (go && !busy)
        begin
            ph <= ph + (jump ? 2'h2 : (back ? 2'h3 : 2'h1));
            wait_cnt <= GAP_CYC;
        end
        else if (wait_cnt != 0)
        begin
            wait_cnt <= wait_cnt - 1;
        end
    end
    assign busy = (wait_cnt != 0);
    assign ch_a = ph[1] ^ ph[0];
    assign ch_b = ph[1];
endmodule
`default_nettype wire

/* test/quadrature_position_input_tb.sv */
// Self-checking bench for the encoder position input block.
`timescale 1ns/1ps
`default_nettype none
module quadrature_position_input_tb;
    // The decoder has no interval timer, but the gap also keeps the motor behind its target at the direction check and the run inside its time limit.
    localparam int unsigned GAP = 1000;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic motor_power = 1'b0;
    logic go = 1'b0;
    logic back = 1'b0;
    logic jump = 1'b0;
    logic swap = 1'b0;
    logic ser_txd = 1'b1;
    logic tx_out;
    int steps = 0;
    logic [31:0] rdata;
    logic ka, kb, busy, tx_oe_n, pullup_en, step_out, dir_out, irq;
    int bad_count = 0;
    int cmp_count = 0;
    always #5 clk = ~clk;
    always @(posedge clk)
        if (step_out)
            steps <= steps + 1;
    enc_knob #(.GAP_CYC(GAP)) i_enc_knob (.clk(clk), .go(go), .back(back), .jump(jump),
        .ch_a(ka), .ch_b(kb), .busy(busy));
    quadrature_position_input #(.STEP_DIV(4)) i_quadrature_position_input (.clk(clk), .srst(srst),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .rx_pin(swap ? kb : ka), .tx_pin_in(swap ? ka : kb), .ser_txd(ser_txd), .tx_out(tx_out),
        .tx_oe_n(tx_oe_n), .pullup_en(pullup_en), .motor_power(motor_power),
        .step_out(step_out), .dir_out(dir_out), .irq(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic turn(input logic b, input logic j, input int n);
        repeat (n)
        begin
            @(posedge clk);
            go <= 1'b1;
            back <= b;
            jump <= j;
            @(posedge clk);
            go <= 1'b0;
            repeat (GAP + 8) @(posedge clk);
        end
    endtask
    task automatic end_sim;
        if (bad_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clk);
        bad_count++;
        end_sim;
    end
    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rd(8'h00, 32'h0000_0000);
        rd(8'h04, 32'h0000_0001);
        rd(8'h08, 32'h0000_0001);
        rd(8'h0C, 32'h0000_00C8);
        rd(8'h10, 32'hFFFF_FF38);
        rd(8'h40, 32'h0000_0000);
        @(posedge clk) ser_txd <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({31'h0000_0000, tx_out}, 32'h0000_0000);
        wr(8'h0C, 32'hFFFF_FFFF);
        rd(8'h0C, 32'h0000_0000);
        wr(8'h10, 32'h0000_0005);
        rd(8'h10, 32'h0000_0000);
        wr(8'h10, 32'hFFFF_FF38);
        wr(8'h0C, 32'h0000_00C8);
        wr(8'h00, 32'h0000_0001);
        repeat (3) @(posedge clk);
        #1 chk({30'h0000_0000, pullup_en, tx_oe_n}, 32'h0000_0003);
        turn(1'b0, 1'b0, 2);
        rd(8'h14, 32'h0000_0000);
        @(posedge clk) motor_power <= 1'b1;
        turn(1'b0, 1'b0, 4);
        rd(8'h14, 32'h0000_0004);
        rd(8'h18, 32'h0000_0004);
        rd(8'h1C, 32'h0000_0004);
        chk(steps, 32'h0000_0004);
        @(posedge clk) swap <= 1'b1;
        turn(1'b0, 1'b0, 2);
        rd(8'h14, 32'h0000_0002);
        @(posedge clk) swap <= 1'b0;
        wr(8'h28, 32'h0000_0001);
        turn(1'b0, 1'b1, 1);
        rd(8'h20, 32'h0000_0001);
        rd(8'h14, 32'h0000_0002);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        wr(8'h2C, 32'h0000_0001);
        repeat (3) @(posedge clk);
        #1 chk({31'h0000_0000, irq}, 32'h0000_0000);
        rd(8'h24, 32'h0000_0004);
        wr(8'h04, 32'h0000_0002);
        wr(8'h08, 32'h0000_0003);
        turn(1'b0, 1'b0, 3);
        rd(8'h18, 32'h0000_0005);
        wr(8'h0C, 32'h0000_0006);
        turn(1'b0, 1'b0, 1);
        rd(8'h18, 32'h0000_0006);
        rd(8'h24, 32'h0000_0006);
        wr(8'h00, 32'h0000_0003);
        turn(1'b0, 1'b0, 2);
        rd(8'h18, 32'h0000_0009);
        // A large step keeps the target ahead of the motor while the pin is read.
        wr(8'h08, 32'h0000_03E8);
        wr(8'h00, 32'h0000_0007);
        turn(1'b0, 1'b0, 2);
        #1 chk({31'h0000_0000, dir_out}, 32'h0000_0000);
        wr(8'h00, 32'h0000_0003);
        repeat (3) @(posedge clk);
        #1 chk({31'h0000_0000, dir_out}, 32'h0000_0001);
        end_sim;
    end
endmodule
`default_nettype wire
